// ===== rtl/spg_map.svh
`ifndef SPG_MAP_SVH
`define SPG_MAP_SVH

// Register indices; byte address on the bus is four times the index
`define SPG_IDX_REVISION 6'h0A
`define SPG_IDX_CTRL 6'h0E
`define SPG_IDX_OUT_DATA 6'h0F
`define SPG_IDX_IN_DATA 6'h10

// Address layout
`define SPG_ADDR_W 8
`define SPG_DATA_W 32
`define SPG_WORD_LSB 2

// Port control fields
`define SPG_PIN_COUNT 5
`define SPG_CTRL_ENABLE_BIT 7
`define SPG_CTRL_DIR_MSB 4
`define SPG_CTRL_DIR_LSB 0

// Pin roles on shared pads
`define SPG_FILTER_PIN 4
`define SPG_CONFIG_MSB 3

// Reset values
`define SPG_CTRL_RESET 8'h00
`define SPG_OUT_RESET 8'h00
`define SPG_IN_RESET 8'h00
`define SPG_PIN_RESET 5'h00
`define SPG_RDATA_RESET 32'h00000000

// Revision code default, value is arbitrary
`define SPG_REV_CODE_DEFAULT 8'h5A

`endif

// ===== rtl/spg_pkg.sv
package spg_pkg;

   typedef enum logic [1:0] {
      SPG_PH_IDLE = 2'b00,
      SPG_PH_SETUP = 2'b01,
      SPG_PH_ACCESS = 2'b10
   } spg_apb_phase_t;

   typedef enum logic [2:0] {
      SPG_SEL_NONE = 3'b000,
      SPG_SEL_REV = 3'b001,
      SPG_SEL_CTRL = 3'b010,
      SPG_SEL_OUT = 3'b011,
      SPG_SEL_IN = 3'b100
   } spg_reg_sel_t;

endpackage : spg_pkg

// ===== rtl/spg_pin_cell.sv
`timescale 1ns/1ns
`include "spg_map.svh"

module spg_pin_cell (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic gpioActive,
   input wire logic pinDir,
   input wire logic pinOutValue,
   input wire logic padInLevel,
   output logic padDrive,
   output logic padDriveEn,
   output logic pinInLevel,
   output logic strapLevel
);

   logic padDrive_ff;
   logic padDriveEn_ff;
   logic pinInLevel_ff;
   logic strapLevel_ff;
   wire drivesPad = gpioActive & pinDir;
   wire readsPad = gpioActive & ~pinDir;

   // Output value forced low when not driving so an idle pad shows no stale data
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         padDrive_ff <= 1'b0;
         padDriveEn_ff <= 1'b0;
         pinInLevel_ff <= 1'b0;
         strapLevel_ff <= 1'b0;
      end else begin
         padDriveEn_ff <= drivesPad;
         padDrive_ff <= drivesPad & pinOutValue;
         pinInLevel_ff <= readsPad & padInLevel;
         strapLevel_ff <= padInLevel;
      end
   end

   assign padDrive = padDrive_ff;
   assign padDriveEn = padDriveEn_ff;
   assign pinInLevel = pinInLevel_ff;
   assign strapLevel = strapLevel_ff;

endmodule : spg_pin_cell

// ===== rtl/spg_apb_slave.sv
`timescale 1ns/1ns
`include "spg_map.svh"

module spg_apb_slave (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SPG_ADDR_W-1:0] paddr,
   output logic pready,
   output logic pslverr,
   output spg_pkg::spg_reg_sel_t regSel,
   output logic wrStrobe,
   output logic rdSetup
);

   spg_pkg::spg_apb_phase_t phase_ff;
   spg_pkg::spg_apb_phase_t nxt_phase;
   wire [5:0] wordIdx = paddr[`SPG_ADDR_W-1:`SPG_WORD_LSB];
   wire aligned = (paddr[`SPG_WORD_LSB-1:0] == 2'h0);
   wire setupCycle = psel & ~penable;
   wire accessCycle = psel & penable;
   wire mapped = (regSel != spg_pkg::SPG_SEL_NONE);

   assign regSel = !aligned ? spg_pkg::SPG_SEL_NONE :
                   (wordIdx == `SPG_IDX_REVISION) ? spg_pkg::SPG_SEL_REV :
                   (wordIdx == `SPG_IDX_CTRL) ? spg_pkg::SPG_SEL_CTRL :
                   (wordIdx == `SPG_IDX_OUT_DATA) ? spg_pkg::SPG_SEL_OUT :
                   (wordIdx == `SPG_IDX_IN_DATA) ? spg_pkg::SPG_SEL_IN :
                   spg_pkg::SPG_SEL_NONE;

   // Zero wait states: read data is latched in setup, so access can complete at once
   assign pready = 1'b1;
   assign pslverr = accessCycle & ~mapped;
   assign wrStrobe = accessCycle & pwrite & mapped & (phase_ff == spg_pkg::SPG_PH_SETUP);
   assign rdSetup = setupCycle & ~pwrite;

   always_comb begin
      case (phase_ff)
         spg_pkg::SPG_PH_IDLE: begin
            nxt_phase = setupCycle ? spg_pkg::SPG_PH_SETUP : spg_pkg::SPG_PH_IDLE;
         end
         spg_pkg::SPG_PH_SETUP: begin
            nxt_phase = accessCycle ? spg_pkg::SPG_PH_ACCESS : spg_pkg::SPG_PH_IDLE;
         end
         spg_pkg::SPG_PH_ACCESS: begin
            nxt_phase = setupCycle ? spg_pkg::SPG_PH_SETUP : spg_pkg::SPG_PH_IDLE;
         end
         default: begin
            nxt_phase = spg_pkg::SPG_PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         phase_ff <= spg_pkg::SPG_PH_IDLE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

endmodule : spg_apb_slave

// ===== rtl/spg_port.sv
`timescale 1ns/1ns
`include "spg_map.svh"

// How it works
// - Pins act as general-purpose only in serial register control mode.
// - Control bit 7 enables all five pins together; resets to zero.
// - Control bits 4 to 0 set pin direction, one is output.
// - Pin 4 shares filter strap; pins 0 to 3 share config straps.
// - Output data bits 4 to 0 drive enabled output pins.
// - Input data register returns sampled input pin levels; read-only, resets zero.
// - Fixed read-only 8-bit silicon revision code, unaffected by writes.
// - Control and output data registers are read-write, reset to zero.

module spg_port #(
   parameter logic [7:0] REV_CODE = `SPG_REV_CODE_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SPG_ADDR_W-1:0] paddr,
   input wire logic [`SPG_DATA_W-1:0] pwdata,
   output logic [`SPG_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic spiCtrlMode,
   input wire logic [`SPG_PIN_COUNT-1:0] padIn,
   output logic [`SPG_PIN_COUNT-1:0] padOut,
   output logic [`SPG_PIN_COUNT-1:0] padOe,
   output logic filterStrap,
   output logic [`SPG_CONFIG_MSB:0] configStrap
);

   logic portGlobalEnable_ff;
   logic [`SPG_PIN_COUNT-1:0] pinDirection_ff;
   logic [`SPG_PIN_COUNT-1:0] pinOutValue_ff;
   logic [`SPG_DATA_W-1:0] prdata_ff;
   logic [`SPG_DATA_W-1:0] nxt_prdata;
   logic [`SPG_PIN_COUNT-1:0] pinInLevel;
   logic [`SPG_PIN_COUNT-1:0] strapLevel;
   spg_pkg::spg_reg_sel_t regSel;
   logic wrStrobe;
   logic rdSetup;

   spg_apb_slave u_apb (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pready(pready),
      .pslverr(pslverr),
      .regSel(regSel),
      .wrStrobe(wrStrobe),
      .rdSetup(rdSetup)
   );

   // Write decode; read-only registers simply have no strobe
   wire ctrlWrite = wrStrobe & (regSel == spg_pkg::SPG_SEL_CTRL);
   wire outWrite = wrStrobe & (regSel == spg_pkg::SPG_SEL_OUT);

   // Strapped control mode masks everything, whatever software left in the registers
   wire gpioActive = spiCtrlMode & portGlobalEnable_ff;

   // Readback images, unused bits read as zero
   wire [7:0] revImage = REV_CODE;
   wire [7:0] ctrlImage = {portGlobalEnable_ff, 2'b00, pinDirection_ff};
   wire [7:0] outImage = {3'b000, pinOutValue_ff};
   wire [7:0] inImage = {3'b000, pinInLevel};

   wire [7:0] readByte = (regSel == spg_pkg::SPG_SEL_REV) ? revImage :
                         (regSel == spg_pkg::SPG_SEL_CTRL) ? ctrlImage :
                         (regSel == spg_pkg::SPG_SEL_OUT) ? outImage :
                         (regSel == spg_pkg::SPG_SEL_IN) ? inImage :
                         8'h00;

   // Captured in setup so data is already stable when pready is seen
   assign nxt_prdata = rdSetup ? {24'h000000, readByte} : prdata_ff;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         portGlobalEnable_ff <= 1'b0;
         pinDirection_ff <= `SPG_PIN_RESET;
      end else if (ctrlWrite) begin
         portGlobalEnable_ff <= pwdata[`SPG_CTRL_ENABLE_BIT];
         pinDirection_ff <= pwdata[`SPG_CTRL_DIR_MSB:`SPG_CTRL_DIR_LSB];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pinOutValue_ff <= `SPG_PIN_RESET;
      end else if (outWrite) begin
         pinOutValue_ff <= pwdata[`SPG_PIN_COUNT-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         prdata_ff <= `SPG_RDATA_RESET;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata = prdata_ff;

   // One cell per shared pad
   genvar gi;
   generate
      for (gi = 0; gi < `SPG_PIN_COUNT; gi = gi + 1) begin : g_pin
         spg_pin_cell u_cell (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .gpioActive(gpioActive),
            .pinDir(pinDirection_ff[gi]),
            .pinOutValue(pinOutValue_ff[gi]),
            .padInLevel(padIn[gi]),
            .padDrive(padOut[gi]),
            .padDriveEn(padOe[gi]),
            .pinInLevel(pinInLevel[gi]),
            .strapLevel(strapLevel[gi])
         );
      end
   endgenerate

   // Index order keeps pad i on strap i; pad 4 is the filter select
   assign filterStrap = strapLevel[`SPG_FILTER_PIN];
   assign configStrap = strapLevel[`SPG_CONFIG_MSB:0];

   a_strap_off_pins: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !spiCtrlMode |=> (padOe == 5'h00)
   ) else $error("pad driven while in strapped control");

   a_reset_clears_regs: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !$past(rst_b) |-> (ctrlImage == `SPG_CTRL_RESET) && (outImage == `SPG_OUT_RESET)
   ) else $error("control or output register not zero after reset");

   a_global_gate_all: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (ctrlWrite && !pwdata[`SPG_CTRL_ENABLE_BIT]) |=> ##1 (padOe == 5'h00) [*2]
   ) else $error("pads driven after global disable");

   a_direction_follows: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (spiCtrlMode && portGlobalEnable_ff) |=> (padOe == $past(pinDirection_ff))
   ) else $error("pad enable does not match direction bits");

   a_ctrl_write_effect: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      ctrlWrite |=> (pinDirection_ff == $past(pwdata[4:0]))
                    && (portGlobalEnable_ff == $past(pwdata[7]))
   ) else $error("control write not stored");

   a_strap_mapping: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> (filterStrap == $past(padIn[4])) && (configStrap == $past(padIn[3:0]))
   ) else $error("strap outputs not mapped to matching pads");

   a_output_level: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> (padOut == ($past(pinOutValue_ff) & padOe))
   ) else $error("pad level differs from output data");

   a_out_write_effect: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      outWrite ##1 (!outWrite && !ctrlWrite) |=> outImage == {3'b000, $past(pwdata[4:0], 2)}
   ) else $error("output data write not kept");

   a_input_readback: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> (pinInLevel == ($past(padIn) & ~$past(pinDirection_ff)
                               & {5{$past(gpioActive)}}))
   ) else $error("input register differs from sampled input pads");

   a_revision_read: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (rdSetup && regSel == spg_pkg::SPG_SEL_REV) |=> (prdata == {24'h000000, REV_CODE})
   ) else $error("revision read returned wrong value");

   a_input_read: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (rdSetup && regSel == spg_pkg::SPG_SEL_IN) |=> (prdata == {27'h0, $past(pinInLevel)})
   ) else $error("input read returned wrong value");

   a_no_drive_inputs: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> ((padOe & ~$past(pinDirection_ff)) == 5'h00)
               && (padOe == 5'h00 || $past(gpioActive))
   ) else $error("input or disabled pin is driven");

   a_unmapped_error: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (psel && penable && regSel == spg_pkg::SPG_SEL_NONE) |-> pslverr && pready
   ) else $error("unmapped access not flagged");

   // Registers only move on their own write strobe
   a_enable_holds: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !ctrlWrite |=> $stable(portGlobalEnable_ff)
   ) else $error("global enable changed without a control write");

   a_dir_holds: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !ctrlWrite |=> $stable(pinDirection_ff)
   ) else $error("direction bits changed without a control write");

   a_out_holds: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !outWrite |=> $stable(pinOutValue_ff)
   ) else $error("output data changed without a write");

   a_out_store: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      outWrite |=> (pinOutValue_ff == $past(pwdata[`SPG_PIN_COUNT-1:0]))
   ) else $error("output data write not stored");

   // Pad side gating, one cycle behind the registers
   a_disabled_no_drive: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !portGlobalEnable_ff |=> (padOe == 5'h00)
   ) else $error("pad driven while port disabled");

   a_inactive_out_low: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !gpioActive |=> (padOut == 5'h00)
   ) else $error("pad level shown while port inactive");

   a_undriven_out_low: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      1'b1 |-> ((padOut & ~padOe) == 5'h00)
   ) else $error("output level on a pad that is not driven");

   // Input register only reports enabled input pins
   a_strapped_in_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !spiCtrlMode |=> (pinInLevel == 5'h00)
   ) else $error("input register live in strapped control");

   a_disabled_in_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !portGlobalEnable_ff |=> (pinInLevel == 5'h00)
   ) else $error("input register live while port disabled");

   a_output_in_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> ((pinInLevel & $past(pinDirection_ff)) == 5'h00)
   ) else $error("input register shows an output pin");

   // Read data for the remaining registers
   a_ctrl_read: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (rdSetup && regSel == spg_pkg::SPG_SEL_CTRL)
      |=> (prdata == {24'h000000, $past(portGlobalEnable_ff), 2'b00, $past(pinDirection_ff)})
   ) else $error("control read returned wrong value");

   a_out_read: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (rdSetup && regSel == spg_pkg::SPG_SEL_OUT)
      |=> (prdata == {27'h0, $past(pinOutValue_ff)})
   ) else $error("output data read returned wrong value");

   a_hole_read_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (rdSetup && regSel == spg_pkg::SPG_SEL_NONE) |=> (prdata == 32'h00000000)
   ) else $error("unmapped read returned data");

   a_prdata_holds: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !rdSetup |=> $stable(prdata)
   ) else $error("read data changed outside a read setup");

   // Writes to read-only or unmapped words leave every register alone
   a_rev_write_ignored: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (wrStrobe && regSel == spg_pkg::SPG_SEL_REV)
      |=> $stable(pinOutValue_ff) && $stable(pinDirection_ff) && $stable(portGlobalEnable_ff)
   ) else $error("revision write changed a register");

   a_in_write_ignored: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (wrStrobe && regSel == spg_pkg::SPG_SEL_IN)
      |=> $stable(pinOutValue_ff) && $stable(pinDirection_ff) && $stable(portGlobalEnable_ff)
   ) else $error("input data write changed a register");

   a_hole_write_ignored: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (psel && penable && pwrite && regSel == spg_pkg::SPG_SEL_NONE)
      |=> $stable(pinOutValue_ff) && $stable(pinDirection_ff) && $stable(portGlobalEnable_ff)
   ) else $error("unmapped write changed a register");

   // Bus protocol
   a_err_in_access: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      pslverr |-> (psel && penable)
   ) else $error("error flagged outside an access phase");

   a_write_after_setup: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      wrStrobe |-> ($past(psel) && !$past(penable))
   ) else $error("write taken without a setup cycle");

endmodule : spg_port

// ===== testbench/spg_pad_model.sv
`timescale 1ns/1ns
`include "spg_map.svh"

module spg_pad_model (
   input wire logic clk_sys,
   input wire logic [`SPG_PIN_COUNT-1:0] padOut,
   input wire logic [`SPG_PIN_COUNT-1:0] padOe,
   input wire logic [`SPG_PIN_COUNT-1:0] extLevel,
   input wire logic [`SPG_PIN_COUNT-1:0] extEn,
   output logic [`SPG_PIN_COUNT-1:0] padIn
);
   logic [`SPG_PIN_COUNT-1:0] floatPat;
   initial floatPat = 5'h15;
   // Undriven pads wander, so a stale level cannot pass for a real one
   always @(posedge clk_sys) floatPat <= ~floatPat;
   always_comb begin
      for (int i = 0; i < `SPG_PIN_COUNT; i++) begin
         padIn[i] = padOe[i] ? padOut[i] : (extEn[i] ? extLevel[i] : floatPat[i]);
      end
   end
endmodule : spg_pad_model

// ===== testbench/tb.sv
`timescale 1ns/1ns
`include "spg_map.svh"

module tb;
   localparam logic [7:0] TB_REV = 8'hC3; // Arbitrary revision code
   localparam logic [7:0] A_REV = {`SPG_IDX_REVISION, 2'b00};
   localparam logic [7:0] A_CTRL = {`SPG_IDX_CTRL, 2'b00};
   localparam logic [7:0] A_OUT = {`SPG_IDX_OUT_DATA, 2'b00};
   localparam logic [7:0] A_IN = {`SPG_IDX_IN_DATA, 2'b00};
   logic clk_sys, rst_b, psel, penable, pwrite, spiCtrlMode, pready, pslverr, filterStrap;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [4:0] padIn, padOut, padOe, extLevel, extEn;
   logic [3:0] configStrap;
   int miscompares, checks_done;

   spg_port #(.REV_CODE(TB_REV)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .spiCtrlMode(spiCtrlMode), .padIn(padIn),
      .padOut(padOut), .padOe(padOe), .filterStrap(filterStrap), .configStrap(configStrap));
   spg_pad_model pad_u (.clk_sys(clk_sys), .padOut(padOut), .padOe(padOe),
      .extLevel(extLevel), .extEn(extEn), .padIn(padIn));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Starts on an edge of its own so back-to-back calls never drive twice in one step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
         output logic e);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1);
      chk("pready", 32'h1, {31'h0, pready});
      chk("access cycles", 32'h1, n);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d, input logic expErr);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk("write err", {31'h0, expErr}, {31'h0, e});
   endtask : wr

   task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic expErr, input string nm);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, exp, r);
      chk({nm, " err"}, {31'h0, expErr}, {31'h0, e});
   endtask : rdchk

   task pins(input logic [4:0] oe, input logic [4:0] out);
      repeat (3) @(posedge clk_sys);
      chk("padOe", {27'h0, oe}, {27'h0, padOe});
      chk("padOut", {27'h0, out}, {27'h0, padOut});
   endtask : pins

   task t_reset;
      rdchk(A_REV, {24'h0, TB_REV}, 1'b0, "rev");
      rdchk(A_CTRL, 32'h0, 1'b0, "ctrl");
      rdchk(A_OUT, 32'h0, 1'b0, "out");
      rdchk(A_IN, 32'h0, 1'b0, "in");
      pins(5'h00, 5'h00);
   endtask : t_reset

   task t_regs;
      wr(A_CTRL, 32'hFFFFFFFF, 1'b0);
      rdchk(A_CTRL, 32'h9F, 1'b0, "ctrl");
      wr(A_OUT, 32'hFFFFFFEA, 1'b0);
      rdchk(A_OUT, 32'h0A, 1'b0, "out");
      wr(A_REV, 32'h0, 1'b0);
      rdchk(A_REV, {24'h0, TB_REV}, 1'b0, "rev");
      wr(A_IN, 32'h1F, 1'b0);
      rdchk(A_IN, 32'h0, 1'b0, "in");
      wr(8'h44, 32'h1, 1'b1);
      rdchk(8'h44, 32'h0, 1'b1, "hole");
      rdchk(8'h39, 32'h0, 1'b1, "unaligned");
      wr(A_CTRL, 32'h0, 1'b0);
   endtask : t_regs

   task t_drive;
      extEn <= 5'h00;
      wr(A_OUT, 32'h15, 1'b0);
      pins(5'h00, 5'h00);
      wr(A_CTRL, 32'h1F, 1'b0);
      pins(5'h00, 5'h00);
      wr(A_CTRL, 32'h9F, 1'b0);
      pins(5'h1F, 5'h15);
      wr(A_CTRL, 32'h83, 1'b0);
      pins(5'h03, 5'h01);
      spiCtrlMode <= 1'b0;
      pins(5'h00, 5'h00);
      spiCtrlMode <= 1'b1;
      pins(5'h03, 5'h01);
   endtask : t_drive

   task t_input;
      extEn <= 5'h1C;
      extLevel <= 5'h1A;
      repeat (3) @(posedge clk_sys);
      rdchk(A_IN, 32'h18, 1'b0, "in");
      chk("straps", 32'h19, {27'h0, filterStrap, configStrap});
      wr(A_CTRL, 32'h80, 1'b0);
      extEn <= 5'h1F;
      extLevel <= 5'h0B;
      repeat (3) @(posedge clk_sys);
      rdchk(A_IN, 32'h0B, 1'b0, "in");
      spiCtrlMode <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rdchk(A_IN, 32'h0, 1'b0, "in");
      spiCtrlMode <= 1'b1;
   endtask : t_input

   task print_verdict;
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict

   // Whole sequence needs about 120 cycles
   initial begin
      repeat (3000) @(posedge clk_sys);
      miscompares++;
      print_verdict();
   end

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      spiCtrlMode = 1'b1;
      extLevel = 5'h0A;
      extEn = 5'h1F;
      miscompares = 0;
      checks_done = 0;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset();
      t_regs();
      t_drive();
      t_input();
      print_verdict();
   end
endmodule : tb
